// file: sim/contact_bank.sv
// behavioural bank of external contacts that short each input to common_return
`timescale 1ns/1ns
module contact_bank (
    input wire logic [ctl_input_pkg::NUM_INPUTS-1:0] close_req,
    output logic [ctl_input_pkg::NUM_INPUTS-1:0] pin_n
);
    // open contacts drive the pin high themselves rather than releasing it to a pull-up
    assign pin_n = ~close_req;
endmodule

// file: sim/tb_control_input_decoder.sv
// self-checking bench for the control input decoder
`timescale 1ns/1ns
module tb_control_input_decoder;
    localparam int W = 12;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [12:0] close_q = 13'h0000;
    logic [12:0] pin_n;
    logic backlight_req = 1'b0;
    logic touch_valid = 1'b1;
    logic [12:0] judge_raw = 13'h1ABC;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data;
    logic backlight_on, touch_pass, restart_req, clear_results, judge_continuous;
    logic measure_run, disp_zero, digital_zero;
    logic [4:0] job_number;
    logic [2:0] zone_number;
    logic [12:0] judge_out;
    logic bad_clear = 1'b0;
    int n_rst = 0, n_clr = 0, n_dz = 0, n_gz = 0;
    int miscompares = 0;
    int n_checks = 0;

    always #50 core_clk = ~core_clk;

    contact_bank far_u (.close_req(close_q), .pin_n(pin_n));
    // short debounce keeps each pin change near a dozen cycles
    control_input_decoder #(.DEB_CYCLES(4), .CNT_W(16)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .ext_in_n(pin_n), .backlight_req(backlight_req),
        .touch_valid(touch_valid), .judge_raw(judge_raw), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .backlight_on(backlight_on),
        .touch_pass(touch_pass), .restart_req(restart_req), .job_number(job_number),
        .zone_number(zone_number), .clear_results(clear_results), .judge_continuous(judge_continuous),
        .judge_out(judge_out), .measure_run(measure_run), .disp_zero(disp_zero), .digital_zero(digital_zero)
    );

    // pulses last one cycle, so they are tallied rather than sampled
    always @(posedge core_clk) begin
        if (nrst) begin
            if (restart_req) n_rst <= n_rst + 1;
            if (clear_results) n_clr <= n_clr + 1;
            if (disp_zero) n_dz <= n_dz + 1;
            if (digital_zero) n_gz <= n_gz + 1;
            if (clear_results && judge_out !== 13'h0000) bad_clear <= 1'b1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic pin(input int b, input logic v);
        @(posedge core_clk);
        close_q[b] <= v;
        settle(W);
    endtask

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        print_verdict;
    end

    initial begin
        logic [31:0] d;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        settle(1);
        chk("job_number", 32'(job_number), 32'h1);
        chk("zone_number", 32'(zone_number), 32'h1);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, d);
        chk("unmapped", d, 32'h0);
        rd(ctl_input_pkg::OFS_CFG, d);
        chk("cfg", d, 32'h0000_1F00);
        // a two-cycle bounce must not reach the output
        @(posedge core_clk);
        close_q[0] <= 1'b1;
        repeat (2) @(posedge core_clk);
        close_q[0] <= 1'b0;
        settle(W);
        chk("backlight_glitch", 32'(backlight_on), 32'h0);
        pin(ctl_input_pkg::IN_BACKLIGHT, 1'b1);
        chk("backlight_on", 32'(backlight_on), 32'h1);
        pin(ctl_input_pkg::IN_BACKLIGHT, 1'b0);
        chk("backlight_off", 32'(backlight_on), 32'h0);
        @(posedge core_clk);
        backlight_req <= 1'b1;
        settle(2);
        chk("backlight_req", 32'(backlight_on), 32'h1);
        @(posedge core_clk);
        backlight_req <= 1'b0;
        settle(2);
        chk("backlight_idle", 32'(backlight_on), 32'h0);
        pin(ctl_input_pkg::IN_TOUCH_LOCK, 1'b1);
        chk("touch_locked", 32'(touch_pass), 32'h0);
        pin(ctl_input_pkg::IN_TOUCH_LOCK, 1'b0);
        chk("touch_free", 32'(touch_pass), 32'h1);
        @(posedge core_clk);
        touch_valid <= 1'b0;
        settle(2);
        chk("touch_idle", 32'(touch_pass), 32'h0);
        @(posedge core_clk);
        touch_valid <= 1'b1;
        pin(ctl_input_pkg::IN_RESTART, 1'b1);
        pin(ctl_input_pkg::IN_RESTART, 1'b0);
        chk("restart_count", 32'(n_rst), 32'h1);
        pin(ctl_input_pkg::IN_DISP_ZERO, 1'b1);
        pin(ctl_input_pkg::IN_DISP_ZERO, 1'b0);
        chk("disp_zero_count", 32'(n_dz), 32'h1);
        pin(ctl_input_pkg::IN_DIG_ZERO, 1'b1);
        pin(ctl_input_pkg::IN_DIG_ZERO, 1'b0);
        chk("digital_zero_count", 32'(n_gz), 32'h1);
        chk("judge_pass", 32'(judge_out), 32'h1ABC);
        pin(ctl_input_pkg::IN_MASK, 1'b1);
        chk("judge_masked", 32'(judge_out), 32'h0);
        rd(ctl_input_pkg::OFS_STATUS, d);
        chk("status", d, 32'h0042_0200);
        settle(1);
        chk("rd_data_idle", rd_data, 32'h0);
        pin(ctl_input_pkg::IN_MASK, 1'b0);
        pin(ctl_input_pkg::IN_CLEAR, 1'b1);
        chk("clear_count", 32'(n_clr), 32'h1);
        chk("clear_blank", 32'(bad_clear), 32'h0);
        chk("continuous", 32'(judge_continuous), 32'h1);
        pin(ctl_input_pkg::IN_CLEAR, 1'b0);
        // job pins are ignored while the job source is internal
        @(posedge core_clk);
        close_q[6:3] <= 4'h5;
        settle(W);
        chk("job_internal", 32'(job_number), 32'h1);
        wr(ctl_input_pkg::OFS_SW_JOB, 32'h0000_0009);
        settle(2);
        chk("job_software", 32'(job_number), 32'hA);
        rd(ctl_input_pkg::OFS_SW_JOB, d);
        chk("sw_job", d, 32'h9);
        wr(ctl_input_pkg::OFS_CFG, 32'h0000_1F01);
        for (int v = 0; v < 16; v++) begin
            @(posedge core_clk);
            close_q[6:3] <= 4'(v);
            settle(W);
            chk("job_number", 32'(job_number), 32'(v + 1));
        end
        @(posedge core_clk);
        close_q[6:3] <= 4'h0;
        // only zones 1 and 3 enabled: stepping must skip and wrap
        wr(ctl_input_pkg::OFS_CFG, 32'h0000_0502);
        pin(ctl_input_pkg::IN_ZONE, 1'b1);
        chk("zone_step", 32'(zone_number), 32'h3);
        pin(ctl_input_pkg::IN_ZONE, 1'b0);
        pin(ctl_input_pkg::IN_ZONE, 1'b1);
        chk("zone_wrap", 32'(zone_number), 32'h1);
        pin(ctl_input_pkg::IN_ZONE, 1'b0);
        wr(ctl_input_pkg::OFS_CFG, 32'h0000_1F00);
        pin(ctl_input_pkg::IN_RUN, 1'b1);
        chk("run_internal", 32'(measure_run), 32'h0);
        pin(ctl_input_pkg::IN_RUN, 1'b0);
        wr(ctl_input_pkg::OFS_SW_ZONE, 32'h0000_0004);
        settle(2);
        chk("zone_software", 32'(zone_number), 32'h4);
        pin(ctl_input_pkg::IN_ZONE, 1'b1);
        chk("zone_internal", 32'(zone_number), 32'h4);
        pin(ctl_input_pkg::IN_ZONE, 1'b0);
        wr(ctl_input_pkg::OFS_CMD, 32'h0000_0001);
        settle(3);
        chk("cmd_start", 32'(measure_run), 32'h1);
        chk("continuous_end", 32'(judge_continuous), 32'h0);
        wr(ctl_input_pkg::OFS_CMD, 32'h0000_0002);
        settle(3);
        chk("cmd_stop", 32'(measure_run), 32'h0);
        wr(ctl_input_pkg::OFS_CMD, 32'h0000_0004);
        settle(3);
        chk("clear_cmd_count", 32'(n_clr), 32'h2);
        chk("continuous_again", 32'(judge_continuous), 32'h1);
        wr(ctl_input_pkg::OFS_CFG, 32'h0000_1F0C);
        pin(ctl_input_pkg::IN_RUN, 1'b1);
        chk("edge_start", 32'(measure_run), 32'h1);
        pin(ctl_input_pkg::IN_RUN, 1'b0);
        chk("edge_hold", 32'(measure_run), 32'h1);
        pin(ctl_input_pkg::IN_RUN, 1'b1);
        chk("edge_stop", 32'(measure_run), 32'h0);
        pin(ctl_input_pkg::IN_RUN, 1'b0);
        wr(ctl_input_pkg::OFS_CFG, 32'h0000_1F1C);
        pin(ctl_input_pkg::IN_RUN, 1'b1);
        chk("level_start", 32'(measure_run), 32'h1);
        pin(ctl_input_pkg::IN_RUN, 1'b0);
        chk("level_stop", 32'(measure_run), 32'h0);
        print_verdict;
    end
endmodule

// file: verilog/control_input_decoder.sv
// isolated control input decoder: sync, debounce, command decode, register port
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
module control_input_decoder #(
    parameter int DEB_CYCLES = ctl_input_pkg::DEBOUNCE_CYCLES,
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [ctl_input_pkg::NUM_INPUTS-1:0] ext_in_n,
    input wire logic backlight_req,
    input wire logic touch_valid,
    input wire logic [ctl_input_pkg::JUDGE_W-1:0] judge_raw,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    output logic backlight_on,
    output logic touch_pass,
    output logic restart_req,
    output logic [4:0] job_number,
    output logic [2:0] zone_number,
    output logic clear_results,
    output logic judge_continuous,
    output logic [ctl_input_pkg::JUDGE_W-1:0] judge_out,
    output logic measure_run,
    output logic disp_zero,
    output logic digital_zero
);
    localparam int N = ctl_input_pkg::NUM_INPUTS;
    localparam int NZ = ctl_input_pkg::NUM_ZONES;

    // next enabled zone after cur, wrapping; stays put if none enabled
    function automatic logic [2:0] next_zone(input logic [2:0] cur, input logic [NZ-1:0] en);
        logic [2:0] z;
        logic [2:0] res;
        logic found;
        z = cur;
        res = cur;
        found = 1'b0;
        for (int k = 0; k < NZ; k++) begin
            z = (z >= 3'(NZ)) ? ctl_input_pkg::ZONE_FIRST : 3'(z + 3'h1);
            if (!found && en[z - 3'h1]) begin
                res = z;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // synchroniser and debounce
    logic [N-1:0] s1_q, s2_q, deb_q, deb_d, prev_q;
    logic [CNT_W-1:0] cnt_q [N];
    logic [CNT_W-1:0] cnt_d [N];
    logic [N-1:0] rise, fall;

    always_comb begin
        deb_d = deb_q;
        for (int i = 0; i < N; i++) begin
            cnt_d[i] = '0;
            // pin low means shorted to common_return, i.e. ON
            if (~s2_q[i] != deb_q[i]) begin
                if (cnt_q[i] >= CNT_W'(DEB_CYCLES - 1)) begin
                    deb_d[i] = ~s2_q[i];
                end else begin
                    cnt_d[i] = CNT_W'(cnt_q[i] + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s1_q <= '1;
            s2_q <= '1;
            deb_q <= '0;
            prev_q <= '0;
            for (int i = 0; i < N; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            s1_q <= ext_in_n;
            s2_q <= s1_q;
            deb_q <= deb_d;
            prev_q <= deb_q;
            cnt_q <= cnt_d;
        end
    end

    assign rise = deb_q & ~prev_q;
    assign fall = ~deb_q & prev_q;

    // register port
    logic [12:0] cfg_q, cfg_d;
    logic [3:0] sw_job_q, sw_job_d;
    logic [2:0] sw_zone_q, sw_zone_d;
    logic [2:0] cmd_q, cmd_d;
    logic [31:0] rd_data_q, rd_data_d;
    logic [31:0] status;
    logic run_q, run_d;
    logic [4:0] job_q, job_d;
    logic [2:0] zone_q, zone_d;
    logic cont_q, cont_d;

    always_comb begin
        status = '0;
        status[N-1:0] = deb_q;
        status[ctl_input_pkg::ST_RUN] = run_q;
        status[ctl_input_pkg::ST_JOB_LO +: 5] = job_q;
        status[ctl_input_pkg::ST_ZONE_LO +: 3] = zone_q;
        status[ctl_input_pkg::ST_CONT] = cont_q;
        cfg_d = cfg_q;
        sw_job_d = sw_job_q;
        sw_zone_d = sw_zone_q;
        cmd_d = '0;
        rd_data_d = '0;
        if (wr_en) begin
            case (addr)
                ctl_input_pkg::OFS_CFG: cfg_d = wr_data[12:0];
                ctl_input_pkg::OFS_CMD: cmd_d = wr_data[2:0];
                ctl_input_pkg::OFS_SW_JOB: sw_job_d = wr_data[3:0];
                ctl_input_pkg::OFS_SW_ZONE: sw_zone_d = wr_data[2:0];
                default: cmd_d = '0;
            endcase
        end
        if (rd_en) begin
            case (addr)
                ctl_input_pkg::OFS_CFG: rd_data_d = {19'h0, cfg_q};
                ctl_input_pkg::OFS_STATUS: rd_data_d = status;
                ctl_input_pkg::OFS_SW_JOB: rd_data_d = {28'h0, sw_job_q};
                ctl_input_pkg::OFS_SW_ZONE: rd_data_d = {29'h0, sw_zone_q};
                default: rd_data_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_q <= ctl_input_pkg::CFG_RESET;
            sw_job_q <= '0;
            sw_zone_q <= ctl_input_pkg::ZONE_FIRST;
            cmd_q <= '0;
            rd_data_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            sw_job_q <= sw_job_d;
            sw_zone_q <= sw_zone_d;
            cmd_q <= cmd_d;
            rd_data_q <= rd_data_d;
        end
    end

    // command decode
    logic bl_q, bl_d, tp_q, tp_d, rst_q, rst_d, clr_q, clr_d, dz_q, dz_d, dg_q, dg_d;
    logic [ctl_input_pkg::JUDGE_W-1:0] jo_q, jo_d;
    logic clr_evt, begin_ext, end_ext, start_evt, stop_evt;
    logic [NZ-1:0] zone_en;

    assign begin_ext = cfg_q[ctl_input_pkg::CFG_BEGIN_EXT];
    assign end_ext = cfg_q[ctl_input_pkg::CFG_END_EXT];
    assign zone_en = cfg_q[ctl_input_pkg::CFG_ZEN_HI:ctl_input_pkg::CFG_ZEN_LO];
    assign clr_evt = rise[ctl_input_pkg::IN_CLEAR] | cmd_q[ctl_input_pkg::CMD_CLEAR];

    always_comb begin
        start_evt = cmd_q[ctl_input_pkg::CMD_START] & ~begin_ext;
        stop_evt = cmd_q[ctl_input_pkg::CMD_STOP] & ~end_ext;
        if (cfg_q[ctl_input_pkg::CFG_LEVEL]) begin
            start_evt = start_evt | (rise[ctl_input_pkg::IN_RUN] & begin_ext);
            stop_evt = stop_evt | (fall[ctl_input_pkg::IN_RUN] & end_ext);
        end else begin
            start_evt = start_evt | (rise[ctl_input_pkg::IN_RUN] & ~run_q & begin_ext);
            stop_evt = stop_evt | (rise[ctl_input_pkg::IN_RUN] & run_q & end_ext);
        end
        // stop wins so a conflicting pair never leaves the run flag ambiguous
        run_d = stop_evt ? 1'b0 : (start_evt ? 1'b1 : run_q);
        bl_d = backlight_req | deb_q[ctl_input_pkg::IN_BACKLIGHT];
        tp_d = touch_valid & ~deb_q[ctl_input_pkg::IN_TOUCH_LOCK];
        rst_d = rise[ctl_input_pkg::IN_RESTART];
        if (cfg_q[ctl_input_pkg::CFG_JOB_EXT]) begin
            job_d = 5'({1'b0, deb_q[ctl_input_pkg::IN_JOB8:ctl_input_pkg::IN_JOB1]} + 5'h01);
        end else begin
            job_d = 5'({1'b0, sw_job_q} + 5'h01);
        end
        zone_d = zone_q;
        if (cfg_q[ctl_input_pkg::CFG_ZONE_EXT]) begin
            if (rise[ctl_input_pkg::IN_ZONE]) begin
                zone_d = next_zone(zone_q, zone_en);
            end
        end else begin
            zone_d = sw_zone_q;
        end
        clr_d = clr_evt;
        // continuous judgment runs from a clear until the next measurement start
        cont_d = clr_evt ? 1'b1 : (start_evt ? 1'b0 : cont_q);
        jo_d = (clr_evt || deb_q[ctl_input_pkg::IN_MASK]) ? '0 : judge_raw;
        dz_d = rise[ctl_input_pkg::IN_DISP_ZERO];
        dg_d = rise[ctl_input_pkg::IN_DIG_ZERO];
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            run_q <= 1'b0;
            bl_q <= 1'b0;
            tp_q <= 1'b0;
            rst_q <= 1'b0;
            job_q <= 5'h01;
            zone_q <= ctl_input_pkg::ZONE_FIRST;
            clr_q <= 1'b0;
            cont_q <= 1'b0;
            jo_q <= '0;
            dz_q <= 1'b0;
            dg_q <= 1'b0;
        end else begin
            run_q <= run_d;
            bl_q <= bl_d;
            tp_q <= tp_d;
            rst_q <= rst_d;
            job_q <= job_d;
            zone_q <= zone_d;
            clr_q <= clr_d;
            cont_q <= cont_d;
            jo_q <= jo_d;
            dz_q <= dz_d;
            dg_q <= dg_d;
        end
    end

    assign rd_data = rd_data_q;
    assign backlight_on = bl_q;
    assign touch_pass = tp_q;
    assign restart_req = rst_q;
    assign job_number = job_q;
    assign zone_number = zone_q;
    assign clear_results = clr_q;
    assign judge_continuous = cont_q;
    assign judge_out = jo_q;
    assign measure_run = run_q;
    assign disp_zero = dz_q;
    assign digital_zero = dg_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_backlight_forced: assert property (deb_q[ctl_input_pkg::IN_BACKLIGHT] |=> backlight_on)
        else $error("backlight not forced on");
    a_touch_blocked: assert property (deb_q[ctl_input_pkg::IN_TOUCH_LOCK] |=> !touch_pass)
        else $error("touch passed during lockout");
    a_restart_pulse: assert property (rise[ctl_input_pkg::IN_RESTART] |=> restart_req ##1 !restart_req)
        else $error("restart request not a single pulse");
    a_job_external: assert property (cfg_q[ctl_input_pkg::CFG_JOB_EXT] |=>
        job_number == 5'($past(deb_q[ctl_input_pkg::IN_JOB8:ctl_input_pkg::IN_JOB1]) + 5'h01))
        else $error("job number does not follow job inputs");
    // the new zone is looked up in the enable mask that was in force when the step was taken
    a_zone_enabled: assert property ($changed(zone_number) && $past(cfg_q[ctl_input_pkg::CFG_ZONE_EXT]) |->
        ($past(zone_en) & (NZ'(1) << (zone_number - 3'h1))) != '0)
        else $error("zone switched onto a disabled zone");
    a_clear_outputs: assert property (clr_evt |=> clear_results && judge_out == '0 && judge_continuous)
        else $error("clear did not blank judgment outputs");
    a_mask_outputs: assert property (deb_q[ctl_input_pkg::IN_MASK] |=> judge_out == '0)
        else $error("judgment output active while masked");
    a_edge_toggle: assert property (!cfg_q[ctl_input_pkg::CFG_LEVEL] && begin_ext && end_ext && cmd_q == '0
        && rise[ctl_input_pkg::IN_RUN] |=> measure_run != $past(measure_run))
        else $error("edge style did not toggle measurement");
    a_level_start: assert property (cfg_q[ctl_input_pkg::CFG_LEVEL] && begin_ext
        && rise[ctl_input_pkg::IN_RUN] |=> measure_run)
        else $error("level style did not start measurement");
    a_level_stop: assert property (cfg_q[ctl_input_pkg::CFG_LEVEL] && end_ext
        && fall[ctl_input_pkg::IN_RUN] |=> !measure_run)
        else $error("level style did not stop measurement");
    a_run_ignored: assert property (!begin_ext && !end_ext && cmd_q == '0 |=> $stable(measure_run))
        else $error("run input acted without external condition");
    a_disp_zero_pulse: assert property (rise[ctl_input_pkg::IN_DISP_ZERO] |=> disp_zero ##1 !disp_zero)
        else $error("displacement zero not a single pulse");
    a_dig_zero_pulse: assert property (rise[ctl_input_pkg::IN_DIG_ZERO] |=> digital_zero ##1 !digital_zero)
        else $error("digital zero not a single pulse");
    // every bit that flips must have seen its synchronised pin disagree one cycle earlier
    a_debounce_hold: assert property ($changed(deb_q) |->
        ((deb_q ^ $past(deb_q)) & ($past(s2_q) ^ $past(deb_q))) == '0)
        else $error("debounced level changed without input change");
    // quiet inputs must leave outputs quiet or following their internal sources
    a_backlight_idle: assert property (!deb_q[ctl_input_pkg::IN_BACKLIGHT] && !backlight_req |=>
        !backlight_on)
        else $error("backlight on without any demand");
    a_touch_follow: assert property (!deb_q[ctl_input_pkg::IN_TOUCH_LOCK] |=>
        touch_pass == $past(touch_valid))
        else $error("touch not passed while unlocked");
    a_restart_quiet: assert property (!rise[ctl_input_pkg::IN_RESTART] |=> !restart_req)
        else $error("restart request without input edge");
    a_job_internal: assert property (!cfg_q[ctl_input_pkg::CFG_JOB_EXT] |=>
        job_number == 5'($past(sw_job_q) + 5'h01))
        else $error("job number does not follow software job");
    a_zone_internal: assert property (!cfg_q[ctl_input_pkg::CFG_ZONE_EXT] |=>
        zone_number == $past(sw_zone_q))
        else $error("zone number does not follow software zone");
    a_judge_follow: assert property (!deb_q[ctl_input_pkg::IN_MASK] && !clr_evt |=>
        judge_out == $past(judge_raw))
        else $error("judgment output does not follow its source");
    a_read_idle: assert property (!rd_en |=> rd_data == '0)
        else $error("read data present without a read");

    c_edge_run: cover property (!cfg_q[ctl_input_pkg::CFG_LEVEL] && rise[ctl_input_pkg::IN_RUN] ##1 measure_run);
    c_level_stop: cover property (cfg_q[ctl_input_pkg::CFG_LEVEL] && fall[ctl_input_pkg::IN_RUN] ##1 !measure_run);
    c_zone_step: cover property ($changed(zone_number) && cfg_q[ctl_input_pkg::CFG_ZONE_EXT]);
    c_clear_event: cover property (rise[ctl_input_pkg::IN_CLEAR] ##1 clear_results);
    c_cmd_start: cover property (cmd_q[ctl_input_pkg::CMD_START] && !begin_ext ##1 measure_run);
endmodule

// file: verilog/ctl_input_pkg.sv
// constants for the isolated control input decoder
package ctl_input_pkg;
    localparam int NUM_INPUTS = 13;
    localparam int NUM_ZONES = 5;
    localparam int JUDGE_W = 13;
    // input bit positions, pins are active low (shorted to common_return)
    localparam int IN_BACKLIGHT = 0;
    localparam int IN_TOUCH_LOCK = 1;
    localparam int IN_RESTART = 2;
    localparam int IN_JOB1 = 3;
    localparam int IN_JOB8 = 6;
    localparam int IN_ZONE = 7;
    localparam int IN_CLEAR = 8;
    localparam int IN_MASK = 9;
    localparam int IN_RUN = 10;
    localparam int IN_DISP_ZERO = 11;
    localparam int IN_DIG_ZERO = 12;
    // register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_SW_JOB = 8'h0C;
    localparam logic [7:0] OFS_SW_ZONE = 8'h10;
    // configuration fields
    localparam int CFG_JOB_EXT = 0;
    localparam int CFG_ZONE_EXT = 1;
    localparam int CFG_BEGIN_EXT = 2;
    localparam int CFG_END_EXT = 3;
    localparam int CFG_LEVEL = 4;
    localparam int CFG_ZEN_LO = 8;
    localparam int CFG_ZEN_HI = 12;
    localparam logic [12:0] CFG_RESET = 13'h1F00;
    // command bits (write only, self clearing)
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_CLEAR = 2;
    // status fields
    localparam int ST_RUN = 16;
    localparam int ST_JOB_LO = 17;
    localparam int ST_ZONE_LO = 22;
    localparam int ST_CONT = 25;
    localparam logic [2:0] ZONE_FIRST = 3'h1;
    // debounce time
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEBOUNCE_NS = 1000000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
